// File: rtl/gpm_pkg.sv
`default_nettype none
package gpm_pkg;

  // Configuration byte offsets and their dword addresses
  localparam logic [7:0] PM_CAP_OFS   = 8'hD2;
  localparam logic [7:0] PSC_OFS      = 8'hD4;
  localparam logic [7:0] SMI_OFS      = 8'hE0;
  localparam logic [5:0] CAP_DW       = PM_CAP_OFS[7:2];
  localparam logic [5:0] PSC_DW       = PSC_OFS[7:2];
  localparam logic [5:0] SMI_DW       = SMI_OFS[7:2];

  // Capability word, fixed for both functions
  localparam logic [15:0] CAP_RESET   = 16'h0022;
  localparam int          CAP_WAKE_HI = 15;
  localparam int          CAP_WAKE_LO = 11;
  localparam int          CAP_D2_BIT  = 10;
  localparam int          CAP_D1_BIT  = 9;
  localparam int          CAP_INI_BIT = 5;
  localparam int          CAP_CLK_BIT = 3;
  localparam int          CAP_VER_HI  = 2;
  localparam int          CAP_VER_LO  = 0;
  localparam logic [2:0]  CAP_VER     = 3'h2;

  // Control/status word
  localparam logic [15:0] PSC_RESET   = 16'h0000;
  localparam int          PS_HI       = 1;
  localparam int          PS_LO       = 0;
  localparam logic [1:0]  PS_D0       = 2'h0;
  localparam logic [1:0]  PS_D3       = 2'h3;

  // Software SMI word
  localparam logic [15:0] SMI_RESET   = 16'h0000;
  localparam int          SMI_TRIG    = 0;
  localparam int          SMI_FLAG_HI = 7;
  localparam int          SMI_FLAG_LO = 1;
  localparam int          SMI_SCR_HI  = 15;
  localparam int          SMI_SCR_LO  = 8;

  // Function numbers of the device
  localparam logic        FUNC_PRI    = 1'h0;
  localparam logic        FUNC_SEC    = 1'h1;

  typedef enum logic {ACC_IDLE, ACC_DONE} gpm_acc_t;

endpackage
`default_nettype wire

// File: rtl/gpm_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gpm_ctl_if;
  logic        ce;
  logic        wr_psc;
  logic        wr_smi_lo;
  logic        wr_smi_hi;
  logic [15:0] wdata;
  logic [1:0]  ps;
  logic        init;
  logic [15:0] smi_word;
  modport top (output ce, wr_psc, wr_smi_lo, wr_smi_hi, wdata, input ps, init, smi_word);
  modport pst (input ce, wr_psc, wdata, output ps, init);
  modport smi (input ce, wr_smi_lo, wr_smi_hi, wdata, output smi_word);
endinterface
`default_nettype wire

// File: rtl/gpm_pstate.sv
`timescale 1ns/1ps
`default_nettype none
module gpm_pstate
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  gpm_ctl_if.pst    c
);
  import gpm_pkg::*;

  logic [1:0] ps_ff;
  logic [1:0] nxt_ps;
  logic       init_ff;
  logic       nxt_init;

  // Only D0 and D3 are taken; other codes are dropped silently
  always_comb
  begin
    nxt_ps   = ps_ff;
    nxt_init = 1'b0;
    if (c.wr_psc && (c.wdata[PS_HI:PS_LO] == PS_D0 || c.wdata[PS_HI:PS_LO] == PS_D3))
    begin
      nxt_ps   = c.wdata[PS_HI:PS_LO];
      nxt_init = (ps_ff == PS_D3) && (c.wdata[PS_HI:PS_LO] == PS_D0);
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ps_ff   <= PSC_RESET[PS_HI:PS_LO];
      init_ff <= 1'b0;
    end
    else if (c.ce)
    begin
      ps_ff   <= nxt_ps;
      init_ff <= nxt_init;
    end
  end

  assign c.ps   = ps_ff;
  assign c.init = init_ff;
endmodule
`default_nettype wire

// File: rtl/gpm_smi.sv
`timescale 1ns/1ps
`default_nettype none
module gpm_smi
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  gpm_ctl_if.smi    c
);
  import gpm_pkg::*;

  logic [15:0] word_ff;
  logic [15:0] nxt_word;

  // Trigger bit stays set until software writes it back to zero
  always_comb
  begin
    nxt_word = word_ff;
    if (c.wr_smi_lo)
    begin
      nxt_word[SMI_FLAG_HI:SMI_FLAG_LO] = c.wdata[SMI_FLAG_HI:SMI_FLAG_LO];
      nxt_word[SMI_TRIG]                = c.wdata[SMI_TRIG];
    end
    if (c.wr_smi_hi)
    begin
      nxt_word[SMI_SCR_HI:SMI_SCR_LO] = c.wdata[SMI_SCR_HI:SMI_SCR_LO];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      word_ff <= SMI_RESET;
    end
    else if (c.ce)
    begin
      word_ff <= nxt_word;
    end
  end

  assign c.smi_word = word_ff;
endmodule
`default_nettype wire

// File: rtl/gpm_regs.sv
// Behaviour
// - Capability word is one fixed source, read alike from both functions.
// - Wake-event support field of the capability word reads zero.
// - D2 and D1 support bits read zero.
// - Special-initialisation bit reads one.
// - Wake-clock bit reads zero.
// - Version field reads the fixed code 010b.
// - Wake-event status bit of control/status always reads zero.
// - Data scale and data select fields read zero; writes ignored.
// - Wake-event enable bit reads zero.
// - Power state field resets to D0, reads back, accepts D0 and D3.
// - Writes of D1 or D2 complete normally but change nothing.
// - Going from D3 to D0 may reinitialise the graphics controller.
// - SMI is raised while the trigger bit is set; software clears it.
// - SMI word holds a scratch byte and a seven-bit flag field.
// - SMI word stays at its fixed configuration location.
`timescale 1ns/1ps
`default_nettype none
module gpm_regs
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic        cfg_func,
  input  wire logic [5:0]  cfg_dw_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic [31:0]      cfg_rdata,
  output logic [1:0]       power_state,
  output logic             smi_req,
  output logic             gfx_init
);
  import gpm_pkg::*;

  gpm_ctl_if c ();

  gpm_acc_t    acc_ff;
  gpm_acc_t    nxt_acc;
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        take;
  logic        hit_psc;
  logic        hit_smi;
  logic [15:0] psc_word;

  // A request is taken only from idle; the requester holds it until ack
  assign take = ce && cfg_req && (acc_ff == ACC_IDLE);

  // Control/status belongs to this function; SMI word is written via function 0
  assign hit_psc  = (cfg_dw_addr == PSC_DW) && (cfg_func == FUNC_SEC);
  assign hit_smi  = (cfg_dw_addr == SMI_DW) && (cfg_func == FUNC_PRI);

  // Only the power state bits are stored; everything else is a constant zero
  assign psc_word = {14'h0000, c.ps};

  // Write strobes; writes to the capability word or unmapped space are dropped
  assign c.ce        = ce;
  assign c.wr_psc    = take && cfg_we && hit_psc && cfg_be[0];
  assign c.wr_smi_lo = take && cfg_we && hit_smi && cfg_be[0];
  assign c.wr_smi_hi = take && cfg_we && hit_smi && cfg_be[1];
  assign c.wdata     = cfg_wdata[15:0];

  gpm_pstate u_pstate
  (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .c       (c.pst)
  );

  gpm_smi u_smi
  (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .c       (c.smi)
  );

  // Access sequencer: one cycle to take, one cycle to answer
  always_comb
  begin
    nxt_acc = acc_ff;
    nxt_ack = 1'b0;
    case (acc_ff)
      ACC_IDLE:
      begin
        if (take)
        begin
          nxt_acc = ACC_DONE;
          nxt_ack = 1'b1;
        end
      end
      ACC_DONE:
      begin
        nxt_acc = ACC_IDLE;
      end
      default:
      begin
        nxt_acc = ACC_IDLE;
      end
    endcase
  end

  // Read mux; the capability sits in the upper half of its dword
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (take)
    begin
      if (cfg_we)
      begin
        nxt_rdata = 32'h0000_0000;
      end
      else if (cfg_dw_addr == CAP_DW)
      begin
        nxt_rdata = {CAP_RESET, 16'h0000};
      end
      else if (hit_psc)
      begin
        nxt_rdata = {16'h0000, psc_word};
      end
      else if (cfg_dw_addr == SMI_DW)
      begin
        nxt_rdata = {16'h0000, c.smi_word};
      end
      else
      begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  // Answer registers; a frozen cycle stretches the ack until ce returns
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_ff   <= ACC_IDLE;
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else if (ce)
    begin
      acc_ff   <= nxt_acc;
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs straight from flip-flops
  assign cfg_ack     = ack_ff;
  assign cfg_rdata   = rdata_ff;
  assign power_state = c.ps;
  assign smi_req     = c.smi_word[SMI_TRIG];
  assign gfx_init    = c.init;

  // Decoded reads, watched by the checks below
  logic rd_cap;
  logic rd_psc;
  logic rd_smi;
  logic rd_none;
  assign rd_cap  = take && !cfg_we && (cfg_dw_addr == CAP_DW);
  assign rd_psc  = take && !cfg_we && hit_psc;
  assign rd_smi  = take && !cfg_we && (cfg_dw_addr == SMI_DW);
  assign rd_none = take && !cfg_we && (cfg_dw_addr != CAP_DW) && !hit_psc && (cfg_dw_addr != SMI_DW);

  AST_CAP_BOTH_FUNCS: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_cap |=> cfg_ack && (cfg_rdata == 32'h0022_0000))
    else $error("capability word differs from fixed value");

  AST_CAP_WAKE_ZERO: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_cap |=> cfg_rdata[31:27] == 5'h00)
    else $error("wake support field not zero");

  AST_CAP_D1_D2_ZERO: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_cap |=> (cfg_rdata[26] == 1'b0) && (cfg_rdata[25] == 1'b0))
    else $error("intermediate power state advertised");

  AST_CAP_INIT_ONE: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_cap |=> cfg_rdata[21] == 1'b1)
    else $error("special init bit not set");

  AST_CAP_CLK_ZERO: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_cap |=> cfg_rdata[19] == 1'b0)
    else $error("wake clock bit set");

  AST_CAP_VERSION: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_cap |=> cfg_rdata[18:16] == 3'h2)
    else $error("version code wrong");

  AST_PSC_WAKE_STS: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_psc |=> cfg_rdata[15] == 1'b0)
    else $error("wake status bit set");

  AST_PSC_DATA_ZERO: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_psc |=> cfg_rdata[14:9] == 6'h00)
    else $error("data scale or select not zero");

  AST_PSC_WAKE_EN: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_psc |=> cfg_rdata[8] == 1'b0)
    else $error("wake enable bit set");

  AST_PS_READBACK: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_psc |=> cfg_rdata[31:0] == {30'h0000_0000, power_state})
    else $error("power state readback wrong");

  AST_PS_ACCEPT: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    c.wr_psc && (cfg_wdata[1:0] == 2'h3 || cfg_wdata[1:0] == 2'h0)
    |=> power_state == $past(cfg_wdata[1:0]))
    else $error("supported power state not taken");

  AST_PS_DISCARD: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    c.wr_psc && (cfg_wdata[1:0] == 2'h1 || cfg_wdata[1:0] == 2'h2)
    |=> $stable(power_state) && cfg_ack)
    else $error("unsupported power state changed state");

  AST_INIT_ON_WAKE: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    c.wr_psc && (power_state == 2'h3) && (cfg_wdata[1:0] == 2'h0)
    |=> gfx_init && (power_state == 2'h0))
    else $error("no reinit pulse on D3 to D0");

  AST_INIT_CAUSE: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(gfx_init) |-> $past(power_state) == 2'h3)
    else $error("reinit pulse without leaving D3");

  AST_SMI_CLEAR: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    c.wr_smi_lo && !cfg_wdata[0] |=> !smi_req)
    else $error("smi not cleared by zero write");

  AST_SMI_HOLD: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    smi_req && !c.wr_smi_lo |=> smi_req)
    else $error("smi dropped without software clear");

  AST_SMI_SCRATCH: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    c.wr_smi_hi |=> c.smi_word[15:8] == $past(cfg_wdata[15:8]))
    else $error("scratch byte not stored");

  AST_SMI_LOCATION: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_smi |=> cfg_rdata == {16'h0000, $past(c.smi_word)})
    else $error("smi word not at its location");

  AST_UNMAPPED_ZERO: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_none |=> cfg_ack && (cfg_rdata == 32'h0000_0000))
    else $error("unmapped read not zero");

  AST_ACK_PULSE: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    take |=> cfg_ack ##1 (!cfg_ack || !$past(ce)))
    else $error("ack not a single pulse");

  // A frozen cycle must leave every register as it was
  AST_CE_HOLD_PS: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !ce |=> $stable(power_state))
    else $error("power state moved while frozen");

  AST_CE_HOLD_SMI: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !ce |=> $stable(c.smi_word))
    else $error("smi word moved while frozen");

  AST_CE_HOLD_ANSWER: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !ce |=> $stable(cfg_ack) && $stable(cfg_rdata))
    else $error("answer moved while frozen");

  AST_ACK_NEEDS_TAKE: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(cfg_ack) |-> $past(take))
    else $error("ack without a taken request");

  AST_PSC_RSVD_ZERO: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_psc |=> (cfg_rdata[31:16] == 16'h0000) && (cfg_rdata[7:2] == 6'h00))
    else $error("reserved control bits not zero");

  AST_PS_ENCODING: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (power_state == 2'h0) || (power_state == 2'h3))
    else $error("power state holds an unsupported code");

  AST_PS_WRITE_ONLY: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !c.wr_psc |=> $stable(power_state))
    else $error("power state changed without a write");

  AST_SMI_WRITE_ONLY: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !c.wr_smi_lo && !c.wr_smi_hi |=> $stable(c.smi_word))
    else $error("smi word changed without a write");

  AST_SMI_FLAGS: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    c.wr_smi_lo |=> c.smi_word[7:1] == $past(cfg_wdata[7:1]))
    else $error("flag field not stored");

  AST_SMI_SET: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    c.wr_smi_lo && cfg_wdata[0] |=> smi_req)
    else $error("smi not raised by a one write");

  AST_INIT_ONE_CYCLE: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    gfx_init && ce |=> !gfx_init)
    else $error("reinit pulse longer than one cycle");

  // Main scenarios
  COV_WAKE_FROM_D3: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    power_state == 2'h3 ##[1:20] gfx_init);

  COV_SMI_RAISED: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(smi_req));

  COV_BAD_STATE: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    c.wr_psc && cfg_wdata[1:0] == 2'h2);

  COV_CAP_READ: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_cap ##1 cfg_ack);

  COV_SMI_CLEARED: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    $fell(smi_req));

endmodule
`default_nettype wire

// File: verification/tb_graphics_pm_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_graphics_pm_config_regs;
  import gpm_pkg::*;

  logic        ref_clk;
  logic        resetn;
  logic        ce;
  logic        cfg_req;
  logic        cfg_we;
  logic        cfg_func;
  logic [5:0]  cfg_dw_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata;
  logic        cfg_ack;
  logic [31:0] cfg_rdata;
  logic [1:0]  power_state;
  logic        smi_req;
  logic        gfx_init;
  int          num_errors;
  int          checked;
  logic [31:0] last_rd;
  logic        last_init;

  gpm_regs i_dut (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .ce          (ce),
    .cfg_req     (cfg_req),
    .cfg_we      (cfg_we),
    .cfg_func    (cfg_func),
    .cfg_dw_addr (cfg_dw_addr),
    .cfg_be      (cfg_be),
    .cfg_wdata   (cfg_wdata),
    .cfg_ack     (cfg_ack),
    .cfg_rdata   (cfg_rdata),
    .power_state (power_state),
    .smi_req     (smi_req),
    .gfx_init    (gfx_init)
  );

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: seen 0x%08h expected 0x%08h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons: %0d, mismatches: %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Request is held unchanged until the ack is sampled
  task automatic start_req(input logic f, input logic we, input logic [5:0] a, input logic [3:0] be,
                           input logic [31:0] wd);
    @(posedge ref_clk);
    cfg_req     <= 1'h1;
    cfg_we      <= we;
    cfg_func    <= f;
    cfg_dw_addr <= a;
    cfg_be      <= be;
    cfg_wdata   <= wd;
  endtask

  // Data and init pulse are taken at the edge that sees the ack
  task automatic wait_ack;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (cfg_ack !== 1'h1 && n < 8)
    begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, cfg_ack}, 32'h1);
    last_rd = cfg_rdata;
    last_init = gfx_init;
    cfg_req <= 1'h0;
  endtask

  task automatic acc(input logic f, input logic we, input logic [5:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    start_req(f, we, a, be, wd);
    wait_ack();
  endtask

  task automatic test_reset;
    check({30'h0, power_state}, 32'h0);
    check({31'h0, smi_req}, 32'h0);
    acc(FUNC_SEC, 1'h0, PSC_DW, 4'hF, 32'h0);
    check(last_rd, 32'h0);
    acc(FUNC_PRI, 1'h0, SMI_DW, 4'hF, 32'h0);
    check(last_rd, 32'h0);
  endtask

  // Capability word: wake 0, D2/D1 0, init bit 1, clock bit 0, version 010b
  task automatic test_cap;
    for (int f = 0; f < 2; f++)
    begin
      acc(f[0], 1'h0, CAP_DW, 4'hF, 32'h0);
      check(last_rd, 32'h0022_0000);
      acc(f[0], 1'h1, CAP_DW, 4'hF, 32'hFFFF_FFFF);
      acc(f[0], 1'h0, CAP_DW, 4'hF, 32'h0);
      check(last_rd, 32'h0022_0000);
    end
  endtask

  // Codes 01 and 10 from both D0 and D3, 11 from D0, 00 from D3; only 00 and 11 stick
  task automatic test_pstate;
    logic [1:0] codes [8] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [1:0] exp_ps;
    logic [1:0] prev;
    exp_ps = 2'h0;
    for (int i = 0; i < 8; i++)
    begin
      prev = exp_ps;
      if (codes[i] == 2'h0 || codes[i] == 2'h3)
        exp_ps = codes[i];
      acc(FUNC_SEC, 1'h1, PSC_DW, 4'h1, {30'h0, codes[i]});
      check({31'h0, last_init}, {31'h0, prev == 2'h3 && exp_ps == 2'h0});
      check({30'h0, power_state}, {30'h0, exp_ps});
      acc(FUNC_SEC, 1'h0, PSC_DW, 4'hF, 32'h0);
      check(last_rd, {30'h0, exp_ps});
      check({31'h0, last_init}, 32'h0);
    end
    // All ones lands D3 but no read-only bit may show
    acc(FUNC_SEC, 1'h1, PSC_DW, 4'hF, 32'hFFFF_FFFF);
    acc(FUNC_SEC, 1'h0, PSC_DW, 4'hF, 32'h0);
    check(last_rd, 32'h0000_0003);
    acc(FUNC_SEC, 1'h1, PSC_DW, 4'hF, 32'hFFFF_FFFC);
    acc(FUNC_SEC, 1'h0, PSC_DW, 4'hF, 32'h0);
    check(last_rd, 32'h0);
    // Function 0 has no writable state field here
    acc(FUNC_PRI, 1'h1, PSC_DW, 4'hF, 32'h3);
    check({30'h0, power_state}, 32'h0);
    // Upper lanes alone cannot reach the state field
    acc(FUNC_SEC, 1'h1, PSC_DW, 4'hE, 32'hFFFF_FFFF);
    check({30'h0, power_state}, 32'h0);
  endtask

  task automatic test_smi;
    acc(FUNC_PRI, 1'h1, SMI_DW, 4'h3, 32'hFFFF_A5FF);
    acc(FUNC_SEC, 1'h0, SMI_DW, 4'hF, 32'h0);
    check(last_rd, 32'h0000_A5FF);
    check({31'h0, smi_req}, 32'h1);
    acc(FUNC_SEC, 1'h1, SMI_DW, 4'hF, 32'h0);
    acc(FUNC_PRI, 1'h0, SMI_DW, 4'hF, 32'h0);
    check(last_rd, 32'h0000_A5FF);
    check({31'h0, smi_req}, 32'h1);
    acc(FUNC_PRI, 1'h1, SMI_DW, 4'h1, 32'h0000_0002);
    acc(FUNC_PRI, 1'h0, SMI_DW, 4'hF, 32'h0);
    check(last_rd, 32'h0000_A502);
    check({31'h0, smi_req}, 32'h0);
    acc(FUNC_PRI, 1'h1, SMI_DW, 4'h2, 32'h0000_3CFF);
    acc(FUNC_PRI, 1'h0, SMI_DW, 4'hF, 32'h0);
    check(last_rd, 32'h0000_3C02);
  endtask

  task automatic test_unmapped;
    acc(FUNC_PRI, 1'h1, 6'h00, 4'hF, 32'hFFFF_FFFF);
    acc(FUNC_PRI, 1'h0, 6'h00, 4'hF, 32'h0);
    check(last_rd, 32'h0);
    acc(FUNC_SEC, 1'h0, 6'h3F, 4'hF, 32'h0);
    check(last_rd, 32'h0);
  endtask

  // With the clock enable low a pending write must wait
  task automatic test_ce_freeze;
    @(posedge ref_clk);
    ce <= 1'h0;
    start_req(FUNC_SEC, 1'h1, PSC_DW, 4'h1, 32'h3);
    repeat (4)
    begin
      @(posedge ref_clk);
      check({31'h0, cfg_ack}, 32'h0);
      check({30'h0, power_state}, 32'h0);
    end
    ce <= 1'h1;
    wait_ack();
    check({30'h0, power_state}, 32'h3);
  endtask

  // Reset in mid-run returns state and trigger to defaults
  task automatic test_mid_reset;
    acc(FUNC_PRI, 1'h1, SMI_DW, 4'h1, 32'h1);
    @(posedge ref_clk);
    resetn <= 1'h0;
    repeat (2) @(posedge ref_clk);
    check({30'h0, power_state}, 32'h0);
    check({31'h0, smi_req}, 32'h0);
    check({31'h0, cfg_ack}, 32'h0);
    check({31'h0, gfx_init}, 32'h0);
    resetn <= 1'h1;
    acc(FUNC_SEC, 1'h0, PSC_DW, 4'hF, 32'h0);
    check(last_rd, 32'h0);
  endtask

  initial
  begin
    ref_clk = 1'h0;
    resetn = 1'h0;
    ce = 1'h1;
    cfg_req = 1'h0;
    cfg_we = 1'h0;
    cfg_func = 1'h0;
    cfg_dw_addr = 6'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    num_errors = 0;
    checked = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'h1;
    test_reset();
    test_cap();
    test_pstate();
    test_smi();
    test_unmapped();
    test_ce_freeze();
    test_mid_reset();
    end_of_test();
  end

  // Tests need well under 1000 cycles; 5000 cycles means a hang
  initial
  begin
    #100000;
    num_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
